/* verification/testbench.sv */
// Purpose: Self-checking bench for the chopper current block
// Assumes: Classic Wishbone single cycles, 40 MHz clock
// Notes:   Table cases in one loop, timing cases by hand
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [31:0] conf;
      logic [4:0]  scale;
      logic [7:0]  sine;
      logic [4:0]  adapt;
      logic        run;
      int          offs;
      logic [7:0]  tgt;
      logic [4:0]  eff;
   } row_s;
   logic              clk_i = 1'b0, rst_i = 1'b1;
   logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0]        wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, rd;
   logic              wb_ack_o, cmp_trip_pin_i = 1'b0, cmp_neg_pin_i = 1'b0;
   logic              running_i = 1'b0, bridge_on_o, bridge_fast_o, bridge_enable_o;
   logic [7:0]        sine_i = 8'h00, coil_target_o;
   logic [4:0]        adapt_scale_i = 5'h00, eff_scale_o;
   logic signed [5:0] hyst_o, sine_offset_o, hmax, hmin;
   int                error_cnt = 0, n_compared = 0, cyc = 0, len;
   row_s rows [6] = '{
      '{32'h4001, 5'h1f, 8'hc8, 5'h0a, 1'b1, -3, 8'h44, 5'h0a},
      '{32'h4181, 5'h0f, 8'hc8, 5'h14, 1'b1, 0, 8'h64, 5'h0f},
      '{32'h4781, 5'h00, 8'hff, 5'h00, 1'b1, 12, 8'h07, 5'h00},
      '{32'h4101, 5'h10, 8'h64, 5'h1f, 1'b0, -1, 8'h64, 5'h10},
      '{32'h4201, 5'h1e, 8'h40, 5'h1e, 1'b1, 1, 8'h3e, 5'h1e},
      '{32'h0781, 5'h1f, 8'h01, 5'h1f, 1'b1, 0, 8'h01, 5'h1f}};
   always #12.5 clk_i = ~clk_i;
   chop_current chop_current_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .cmp_trip_pin_i(cmp_trip_pin_i), .cmp_neg_pin_i(cmp_neg_pin_i),
      .running_i(running_i), .sine_i(sine_i), .adapt_scale_i(adapt_scale_i),
      .bridge_on_o(bridge_on_o), .bridge_fast_o(bridge_fast_o),
      .bridge_enable_o(bridge_enable_o), .hyst_o(hyst_o), .sine_offset_o(sine_offset_o),
      .coil_target_o(coil_target_o), .eff_scale_o(eff_scale_o));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   // One classic cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) check("ack", 32'h0, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   // Length of the next fast decay pulse, 0 if none within the wait
   task automatic fast_len(input int wait_max, output int l);
      int n;
      n = 0;
      l = 0;
      while (bridge_fast_o !== 1'b1 && n < wait_max) begin
         @(posedge clk_i);
         n++;
      end
      while (bridge_fast_o === 1'b1 && l < 1000) begin
         @(posedge clk_i);
         l++;
      end
   endtask : fast_len
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 4'h0, 32'h0);
      check("chopconf reset", rd, 32'h0000_0150);
      bus(1'b0, 4'h4, 32'h0);
      check("scale reset", rd, 32'h0000_001f);
      bus(1'b1, 4'h2, 32'hffff_ffff);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", rd, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         running_i <= rows[i].run;
         sine_i <= rows[i].sine;
         adapt_scale_i <= rows[i].adapt;
         bus(1'b1, 4'h0, rows[i].conf);
         bus(1'b1, 4'h4, {27'h0, rows[i].scale});
         repeat (4) @(posedge clk_i);
         check("offset", 32'(sine_offset_o), 32'(rows[i].offs));
         check("target", {24'h0, coil_target_o}, {24'h0, rows[i].tgt});
         check("eff scale", {27'h0, eff_scale_o}, {27'h0, rows[i].eff});
         check("enable on", {30'h0, bridge_enable_o, bridge_on_o}, 32'h3);
         bus(1'b0, 4'h8, 32'h0);
         check("status", rd & 32'h13e, {23'h0, rows[i].run, 2'b0, rows[i].eff, 1'b0});
         bus(1'b0, 4'hc, 32'h0);
         check("sine reg", rd, {24'h0, rows[i].tgt});
      end
      $display("test table done");
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'h0000_0332);
      repeat (3) @(posedge clk_i);
      hmax = hyst_o;
      hmin = hyst_o;
      len = 0;
      repeat (200) begin
         @(posedge clk_i);
         if (hyst_o > hmax) hmax = hyst_o;
         if (hyst_o < hmin) hmin = hyst_o;
         if (hyst_o == 6'sd6) len++;
      end
      check("hyst step", len, 16);
      check("hyst start", 32'(hmax), 32'd7);
      check("hyst end", 32'(hmin), 32'd3);
      $display("test hysteresis done");
      bus(1'b1, 4'h0, 32'h0000_5991);
      fast_len(300, len);
      check("fast before trip", len, 0);
      cmp_trip_pin_i <= 1'b1;
      fast_len(1000, len);
      check("fast length", len, 288);
      bus(1'b1, 4'h0, 32'h0000_4991);
      cmp_neg_pin_i <= 1'b1;
      fast_len(2000, len);
      check("fast cut short", {31'h0, len > 0 && len < 288}, 32'h1);
      cmp_neg_pin_i <= 1'b0;
      bus(1'b1, 4'h0, 32'h0000_5181);
      repeat (40) @(posedge clk_i);
      fast_len(600, len);
      check("slow only", len, 0);
      bus(1'b1, 4'h0, 32'h0000_4000);
      repeat (4) @(posedge clk_i);
      check("freewheel", {29'h0, bridge_enable_o, bridge_on_o, bridge_fast_o}, 32'h0);
      $display("test chopper done");
      bus(1'b1, 4'h4, 32'h0000_0005);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 4'h4, 32'h0);
      check("scale after reset", rd, 32'h0000_001f);
      check("hyst after reset", 32'(hyst_o), 32'h0);
      check("enable after reset", {31'h0, bridge_enable_o}, 32'h0);
      $display("test reset again done");
      close_out();
   end
endmodule : testbench

/* verilog/chop_cfg_if.sv */
// Purpose: Decoded chopper settings between top and timer
// Assumes: One clock
// Notes:   Driven by the register side
interface chop_cfg_if;
   logic [3:0] off_time;
   logic       const_off;
   logic [3:0] fast_decay_time;
   logic       disfdcc;
   modport src (output off_time, const_off, fast_decay_time, disfdcc);
   modport dst (input  off_time, const_off, fast_decay_time, disfdcc);
endinterface : chop_cfg_if

/* verilog/chop_current.sv */
// Purpose: Chopper configuration, hysteresis and current scaling
// Assumes: Classic Wishbone slave, 32-bit data, single clock
// Notes:   Comparator pins are synchronised here
//
// Implementation choices: the Wishbone slave port and the address map.
`include "chop_defs.svh"
module chop_current (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [3:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                cmp_trip_pin_i,
   input  wire logic                cmp_neg_pin_i,
   input  wire logic                running_i,
   input  wire logic [7:0]          sine_i,
   input  wire logic [4:0]          adapt_scale_i,
   output logic                     bridge_on_o,
   output logic                     bridge_fast_o,
   output logic                     bridge_enable_o,
   output logic signed [5:0]        hyst_o,
   output logic signed [5:0]        sine_offset_o,
   output logic [7:0]               coil_target_o,
   output logic [4:0]               eff_scale_o
);
   import chop_pkg::*;
   chop_cfg_if cfg ();
   logic [31:0] chopconf_q;
   logic [4:0]  run_current_scale_q;
   logic [1:0]  trip_sync_q;
   logic [1:0]  neg_sync_q;
   logic [3:0]  hyst_decrementer_cnt_q;
   logic        req;
   logic        wr_commit;
   phase_e      phase;
   logic        cycle_start;
   logic [3:0]  off_time;
   logic [2:0]  hyst_start;
   logic [3:0]  hyst_end;
   logic        fast_decay_msb;
   logic signed [5:0] hyst_end_val;
   logic signed [5:0] hstart_val;
   logic [12:0] scaled;
   logic [4:0]  scale_cap;

   assign off_time       = chopconf_q[`OFF_TIME_LSB +: 4];
   assign hyst_start     = chopconf_q[`HSTART_LSB +: 3];
   assign hyst_end       = chopconf_q[`HYST_END_LSB +: 4];
   assign fast_decay_msb = chopconf_q[`FD_MSB_BIT];
   assign hyst_end_val   = $signed({2'b00, hyst_end}) - $signed(6'(`HYST_END_ZERO));
   assign hstart_val = $signed({3'b000, hyst_start}) + 6'sd1;
   assign cfg.off_time        = off_time;
   assign cfg.const_off       = chopconf_q[`CHM_BIT];
   assign cfg.fast_decay_time = {fast_decay_msb, hyst_start};
   assign cfg.disfdcc         = chopconf_q[`DISFDCC_BIT];
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Write lands at the edge where the master sees ack
   assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   chop_timer u_timer (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .cfg           (cfg),
      .cmp_trip_i    (trip_sync_q[1]),
      .cmp_neg_i     (neg_sync_q[1]),
      .phase_o       (phase),
      .cycle_start_o (cycle_start)
   );

   // Comparator synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trip_sync_q <= 2'b00;
         neg_sync_q  <= 2'b00;
      end else begin
         trip_sync_q <= {trip_sync_q[0], cmp_trip_pin_i};
         neg_sync_q  <= {neg_sync_q[0], cmp_neg_pin_i};
      end
   end

   // Register writes with byte enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chopconf_q          <= `CHOPCONF_RST;
         run_current_scale_q <= `RUN_CURRENT_SCALE_RST;
      end else if (wr_commit) begin
         if (wb_adr_i == `ADR_CHOPCONF) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) chopconf_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end else if (wb_adr_i == `ADR_CURRENT && wb_sel_i[0]) begin
            run_current_scale_q <= wb_dat_i[`RUN_CURRENT_SCALE_LSB +: 5];
         end
      end
   end

   // Bus answer, registered ack one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h0000_0000;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               `ADR_CHOPCONF: wb_dat_o <= chopconf_q;
               `ADR_CURRENT:  wb_dat_o <= {27'h0, run_current_scale_q};
               `ADR_STATUS:   wb_dat_o <= {23'h0, running_i, 2'b00, eff_scale_o, 1'b0};
               `ADR_SINE:     wb_dat_o <= {24'h0, coil_target_o};
               default:       wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Hysteresis decrementer, one step per 16 clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hyst_o     <= 6'sd0;
         hyst_decrementer_cnt_q <= 4'h0;
      end else if (cycle_start) begin
         hyst_o     <= hstart_val + hyst_end_val;
         hyst_decrementer_cnt_q <= 4'h0;
      end else begin
         hyst_decrementer_cnt_q <= hyst_decrementer_cnt_q + 4'h1;
         if (hyst_decrementer_cnt_q == 4'(`HYST_DECREMENTER_CLKS - 5'h01) && hyst_o > hyst_end_val)
            hyst_o <= hyst_o - 6'sd1;
      end
   end

   assign scale_cap = (adapt_scale_i < run_current_scale_q) ? adapt_scale_i
                                                            : run_current_scale_q;
   assign scaled = 13'(sine_i) * 13'({1'b0, scale_cap} + 6'h01);

   // Bridge drive and target, scaled only while running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bridge_on_o     <= 1'b0;
         bridge_fast_o   <= 1'b0;
         bridge_enable_o <= 1'b0;
         sine_offset_o   <= 6'sd0;
         coil_target_o   <= 8'h00;
         eff_scale_o     <= 5'h00;
      end else begin
         bridge_enable_o <= off_time != 4'h0;
         bridge_on_o     <= phase == PH_ON;
         bridge_fast_o   <= phase == PH_FAST;
         sine_offset_o   <= cfg.const_off ? hyst_end_val : 6'sd0;
         eff_scale_o     <= scale_cap;
         coil_target_o   <= running_i ? scaled[`SINE_SHIFT +: 8] : sine_i;
      end
   end

   // Bridge goes quiet: enable first, phase outputs one cycle later
   sequence s_bridge_quiet;
      !bridge_enable_o ##1 (!bridge_fast_o && !bridge_on_o);
   endsequence

   // Hysteresis loaded with start plus end
   sequence s_hyst_loaded;
      hyst_o == $past(hstart_val) + $past(hyst_end_val);
   endsequence

   AST_OFF_DISABLES: assert property (@(posedge clk_i) disable iff (rst_i)
      off_time == 4'h0 |=> s_bridge_quiet)
      else $error("bridge active with zero off time");

   AST_HYST_FLOOR: assert property (@(posedge clk_i) disable iff (rst_i)
      !cycle_start |=> hyst_o == $past(hyst_o) || hyst_o >= $past(hyst_end_val))
      else $error("hysteresis fell below end value");

   AST_HYST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      !cycle_start && hyst_decrementer_cnt_q != 4'(`HYST_DECREMENTER_CLKS - 5'h01) |=> hyst_o == $past(hyst_o))
      else $error("hysteresis stepped between 16 clock marks");

   AST_HYST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      cycle_start |=> s_hyst_loaded)
      else $error("hysteresis not loaded with start plus end");

   AST_SCALE_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
      eff_scale_o <= $past(run_current_scale_q))
      else $error("scale above run current");

   AST_OFFSET_HYST: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg.const_off |=> sine_offset_o == 6'sd0)
      else $error("sine offset applied in hysteresis mode");

   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o)
      else $error("bus request not answered");

   AST_NO_FAST_HYST: assert property (@(posedge clk_i) disable iff (rst_i)
      phase == PH_ON && trip_sync_q[1] && !cfg.const_off && off_time != 4'h0
      |=> phase == PH_SLOW1)
      else $error("hysteresis mode skipped slow decay");

   AST_FD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      phase == PH_ON && trip_sync_q[1] && cfg.const_off && cfg.fast_decay_time == 4'h0
      && off_time != 4'h0 |=> phase == PH_SLOW2)
      else $error("fast decay with zero fast decay time");

   AST_FD_START: assert property (@(posedge clk_i) disable iff (rst_i)
      phase == PH_ON && trip_sync_q[1] && cfg.const_off && cfg.fast_decay_time != 4'h0
      && off_time != 4'h0 |=> phase == PH_FAST)
      else $error("no fast decay after on phase");

   AST_FD_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
      phase == PH_FAST && cfg.const_off && !cfg.disfdcc && neg_sync_q[1]
      && off_time != 4'h0 |=> phase == PH_SLOW2)
      else $error("comparator did not end fast decay");
endmodule : chop_current

/* verilog/chop_defs.svh */
// Purpose: Constants for the chopper current configuration block
// Assumes: Included by its bare name
// Notes:   Offsets are byte addresses on the register bus
`ifndef CHOP_DEFS_SVH
`define CHOP_DEFS_SVH
`define ADR_CHOPCONF  4'h0
`define ADR_CURRENT   4'h4
`define ADR_STATUS    4'h8
`define ADR_SINE      4'hc
`define OFF_TIME_LSB  0
`define HSTART_LSB    4
`define HYST_END_LSB      7
`define FD_MSB_BIT    11
`define DISFDCC_BIT   12
`define CHM_BIT       14
`define RUN_CURRENT_SCALE_LSB      0
`define RUNNING_BIT   8
`define CHOPCONF_RST  32'h0000_0150
`define RUN_CURRENT_SCALE_RST      5'h1f
`define HYST_DECREMENTER_CLKS     5'h10
`define HYST_END_ZERO     5'h03
`define OFF_BASE      10'h018
`define OFF_STEP      10'h020
`define FD_STEP       10'h020
`define SINE_SHIFT    5
`endif

/* verilog/chop_pkg.sv */
// Purpose: Types shared by the chopper block
// Assumes: None
// Notes:   Phases of one chopper cycle
package chop_pkg;
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_ON    = 3'b001,
      PH_FAST  = 3'b010,
      PH_SLOW1 = 3'b011,
      PH_SLOW2 = 3'b100
   } phase_e;
endpackage : chop_pkg

/* verilog/chop_timer.sv */
// Purpose: Phase sequencer for one coil chopper
// Assumes: Comparator inputs already synchronised
// Notes:   Cycle start pulse restarts the hysteresis
`include "chop_defs.svh"
module chop_timer (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   chop_cfg_if.dst            cfg,
   input  wire logic          cmp_trip_i,
   input  wire logic          cmp_neg_i,
   output chop_pkg::phase_e   phase_o,
   output logic               cycle_start_o
);
   import chop_pkg::*;
   logic [9:0] cnt_q;
   logic [9:0] off_len;
   logic [9:0] fd_len;
   // Last count of both slow decay phases and of constant off fast decay, so a phase lasts its full length and no more
   assign off_len = `OFF_BASE + 10'(cfg.off_time) * `OFF_STEP - 10'h001;
   assign fd_len  = 10'(cfg.fast_decay_time) * `FD_STEP - 10'h001;

   always_ff @(posedge clk_i) begin
      if (rst_i || cfg.off_time == 4'h0) begin
         phase_o       <= PH_IDLE;
         cnt_q         <= 10'h000;
         cycle_start_o <= 1'b0;
      end else begin
         cycle_start_o <= 1'b0;
         cnt_q         <= cnt_q + 10'h001;
         case (phase_o)
            PH_IDLE: begin
               phase_o       <= PH_ON;
               cycle_start_o <= 1'b1;
               cnt_q         <= 10'h000;
            end
            PH_ON: if (cmp_trip_i) begin
               cnt_q <= 10'h000;
               if (!cfg.const_off) phase_o <= PH_SLOW1;
               else if (cfg.fast_decay_time == 4'h0) phase_o <= PH_SLOW2;
               else phase_o <= PH_FAST;
            end
            PH_SLOW1: if (cnt_q >= off_len) begin
               phase_o <= PH_FAST;
               cnt_q   <= 10'h000;
            end
            PH_FAST: begin
               if (cfg.const_off) begin
                  if (cnt_q >= fd_len || (!cfg.disfdcc && cmp_neg_i)) begin
                     phase_o <= PH_SLOW2;
                     cnt_q   <= 10'h000;
                  end
               end else if (cmp_trip_i) begin
                  phase_o <= PH_SLOW2;
                  cnt_q   <= 10'h000;
               end
            end
            PH_SLOW2: if (cnt_q >= off_len) begin
               phase_o       <= PH_ON;
               cnt_q         <= 10'h000;
               cycle_start_o <= 1'b1;
            end
            default: phase_o <= PH_IDLE;
         endcase
      end
   end
endmodule : chop_timer
